// file: logic/jtp_pkg.sv
// Shared constants and types for the test access port controller and its host
package jtp_pkg;
	// Controller states, sixteen in all
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} jtp_state_type;

	// Instruction register width and its fixed capture pattern
	localparam int IR_WIDTH = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// Instruction codes (values arbitrary)
	localparam logic [3:0] INSN_IDCODE = 4'h1;
	localparam logic [3:0] INSN_USER = 4'h8;
	localparam logic [3:0] INSN_BYPASS = 4'hF;
	// Data register widths
	localparam int DR_MAX = 32;
	localparam int ID_WIDTH = 32;
	localparam int USER_WIDTH = 8;
	localparam int BYPASS_WIDTH = 1;
	localparam logic [5:0] LEN_ID = 6'h20;
	localparam logic [5:0] LEN_USER = 6'h08;
	localparam logic [5:0] LEN_BYPASS = 6'h01;
	// Identification word (value arbitrary)
	localparam logic [31:0] ID_VALUE = 32'h1234_5679;

	// Host walk lengths, counted as last step index, and the number of mode select highs in the reset walk
	localparam logic [5:0] LAST_RESET = 6'h05;
	localparam logic [5:0] LAST_IR_PRE = 6'h03;
	localparam logic [5:0] LAST_IR_SHIFT = 6'h03;
	localparam logic [5:0] LAST_POST = 6'h01;
	localparam logic [5:0] LAST_DR_PRE = 6'h02;
	localparam logic [5:0] RESET_ONES = 6'h05;

	// Link clock: 320 ns period from a 40 ns system clock
	localparam int CLK_PERIOD_NS = 40;
	localparam int TCK_PERIOD_NS = 320;
	localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int FIFO_DEPTH = 8;
endpackage

// file: logic/jtp_link_if.sv
// Four-wire test link between host and device, with pull-up on the data return
`timescale 1ns/1ns
interface jtp_link_if;
	logic tck;       // Test clock, made by the host
	logic tms;       // Mode select
	logic tdi;       // Serial data toward the device
	logic tdo_drive; // Device data value
	logic tdo_oe;    // Device drives the return line
	logic tdo;       // Resolved return line

	// Pull-up holds the line high while the device does not drive it
	assign tdo = tdo_oe ? tdo_drive : 1'b1;

	modport device (input tck, input tms, input tdi, output tdo_drive, output tdo_oe);
	modport host (output tck, output tms, output tdi, input tdo);
endinterface

// file: logic/jtp_device.sv
// Test access port controller: state machine, instruction and data registers
// Operation
// RULE_01: Sixteen states stepped by mode select on rises
// RULE_02: Power-on reset enters Test-Logic-Reset
// RULE_03: Shift registers move least significant bit first
// RULE_04: Host uses 1,1,0,0 to reach Shift-IR
// RULE_05: Four-bit instruction, last bit on exit
// RULE_06: Instruction shift outputs fixed capture 0x01
// RULE_07: Instruction selects data register and its logic
// RULE_08: Instruction takes effect only in Update-IR
// RULE_09: Exit and pause states do nothing
// RULE_10: Host uses 1,0,0 to reach Shift-DR
// RULE_11: Mode select low until last data bit
// RULE_12: Capture-DR loads parallel inputs for shifting
// RULE_13: Latched data output changes only in Update-DR
// RULE_14: Direct path to data; idle-time functions allowed
// RULE_15: Five mode select highs force Test-Logic-Reset
// RULE_16: No asynchronous test reset input
// RULE_17: Unprogrammed enable fuse holds controller reset
// RULE_18: Return line undriven unless shifting
// RULE_19: Return line changes on falling test clock
`timescale 1ns/1ns
module jtp_device (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic test_port_enable_fuse_in,
	input wire logic test_port_disable_bit_in,
	input wire logic [jtp_pkg::USER_WIDTH-1:0] user_capture_in,
	jtp_link_if.device link,
	output logic [3:0] state_out,
	output logic [jtp_pkg::IR_WIDTH-1:0] instruction_out,
	output logic [jtp_pkg::USER_WIDTH-1:0] user_data_out,
	output logic run_test_active_out,
	output logic port_enabled_out
);
	logic [1:0] tck_sync; // Two-stage synchronisers
	logic [1:0] tms_sync;
	logic [1:0] tdi_sync;
	logic tck_prev; // Last synchronised clock level
	logic tck_rise; // Rising edge seen
	logic tck_fall; // Falling edge seen
	logic enabled; // Port usable
	jtp_pkg::jtp_state_type state;
	jtp_pkg::jtp_state_type next_state;
	logic [jtp_pkg::IR_WIDTH-1:0] ir_shift; // Instruction shift stage
	logic [jtp_pkg::IR_WIDTH-1:0] ir; // Current instruction
	logic [jtp_pkg::DR_MAX-1:0] dr_shift; // Shared data shift stage
	logic [5:0] dr_len; // Length of the selected data register
	logic [jtp_pkg::DR_MAX-1:0] capture_value; // Parallel value for the selected register
	logic tdo_bit; // Bit to present next
	logic tdo_drive;
	logic tdo_oe;

	// Port is live only with the fuse programmed and the disable bit clear
	assign enabled = test_port_enable_fuse_in && !test_port_disable_bit_in;
	assign tck_rise = tck_sync[1] && !tck_prev;
	assign tck_fall = !tck_sync[1] && tck_prev;

	// Pins pass two flip-flops before any logic reads them
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			tck_sync <= 2'h0;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h3;
			tck_prev <= 1'b0;
		end else begin
			tck_sync <= {tck_sync[0], link.tck};
			tms_sync <= {tms_sync[0], link.tms};
			tdi_sync <= {tdi_sync[0], link.tdi};
			tck_prev <= tck_sync[1];
		end
	end

	// Next state from mode select; five highs reach reset from anywhere
	always_comb begin
		next_state = state;
		case (state)
			jtp_pkg::ST_RESET: next_state = tms_sync[1] ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE; // RULE_15
			jtp_pkg::ST_IDLE: next_state = tms_sync[1] ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: next_state = tms_sync[1] ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
			jtp_pkg::ST_SHIFT_DR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
			jtp_pkg::ST_EXIT1_DR: next_state = tms_sync[1] ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAUSE_DR;
			jtp_pkg::ST_PAUSE_DR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT2_DR : jtp_pkg::ST_PAUSE_DR;
			jtp_pkg::ST_EXIT2_DR: next_state = tms_sync[1] ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHIFT_DR;
			jtp_pkg::ST_UPD_DR: next_state = tms_sync[1] ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: next_state = tms_sync[1] ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
			jtp_pkg::ST_SHIFT_IR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
			jtp_pkg::ST_EXIT1_IR: next_state = tms_sync[1] ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAUSE_IR;
			jtp_pkg::ST_PAUSE_IR: next_state = tms_sync[1] ? jtp_pkg::ST_EXIT2_IR : jtp_pkg::ST_PAUSE_IR;
			jtp_pkg::ST_EXIT2_IR: next_state = tms_sync[1] ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHIFT_IR;
			// Update-IR may lead straight into a data scan without idling
			jtp_pkg::ST_UPD_IR: next_state = tms_sync[1] ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE; // RULE_14
			default: next_state = jtp_pkg::ST_RESET;
		endcase
	end

	// State register, stepped on test clock rises; the only resets are
	// power-on, the disabled port and the mode select walk
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state <= jtp_pkg::ST_RESET; // RULE_02
		end else if (!enabled) begin
			state <= jtp_pkg::ST_RESET; // RULE_17
		end else if (tck_rise) begin
			state <= next_state; // RULE_01 RULE_16
		end
	end

	// Instruction picks the data register length and capture value
	always_comb begin
		capture_value = '0;
		if (ir == jtp_pkg::INSN_IDCODE) begin
			dr_len = jtp_pkg::LEN_ID;
			capture_value = jtp_pkg::ID_VALUE; // RULE_07
		end else if (ir == jtp_pkg::INSN_USER) begin
			dr_len = jtp_pkg::LEN_USER;
			capture_value[jtp_pkg::USER_WIDTH-1:0] = user_capture_in; // RULE_07
		end else begin
			dr_len = jtp_pkg::LEN_BYPASS;
		end
	end

	// Instruction path: capture fixed pattern, shift, adopt only in Update-IR
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			ir_shift <= '0;
			ir <= jtp_pkg::INSN_IDCODE;
		end else if (!enabled) begin
			ir <= jtp_pkg::INSN_IDCODE;
		end else if (tck_rise) begin
			case (state)
				jtp_pkg::ST_RESET: ir <= jtp_pkg::INSN_IDCODE;
				jtp_pkg::ST_CAP_IR: ir_shift <= jtp_pkg::IR_CAPTURE; // RULE_06
				// Least significant bit leaves first, new bit enters at the top
				jtp_pkg::ST_SHIFT_IR: ir_shift <= {tdi_sync[1], ir_shift[jtp_pkg::IR_WIDTH-1:1]}; // RULE_03 RULE_05
				jtp_pkg::ST_UPD_IR: ir <= ir_shift; // RULE_08
				default: ir <= ir; // RULE_09
			endcase
		end
	end

	// Data path: capture parallel inputs, shift through the selected length
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			dr_shift <= '0;
		end else if (enabled && tck_rise) begin
			case (state)
				jtp_pkg::ST_CAP_DR: dr_shift <= capture_value; // RULE_12
				jtp_pkg::ST_SHIFT_DR: begin
					// Entry point is the top bit of the selected register
					for (int i = 0; i < jtp_pkg::DR_MAX; i++) begin
						if (i == int'(dr_len) - 1) begin
							dr_shift[i] <= tdi_sync[1]; // RULE_03
						end else if (i < jtp_pkg::DR_MAX - 1) begin
							dr_shift[i] <= dr_shift[i+1];
						end else begin
							dr_shift[i] <= 1'b0;
						end
					end
				end
				default: dr_shift <= dr_shift; // RULE_09
			endcase
		end
	end

	// Latched user output changes only in Update-DR under the user instruction
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			user_data_out <= '0;
		end else if (enabled && tck_rise && state == jtp_pkg::ST_UPD_DR && ir == jtp_pkg::INSN_USER) begin
			user_data_out <= dr_shift[jtp_pkg::USER_WIDTH-1:0]; // RULE_13
		end
	end

	// Bit to present: instruction stage in Shift-IR, data stage otherwise
	assign tdo_bit = (state == jtp_pkg::ST_SHIFT_IR) ? ir_shift[0] : dr_shift[0];

	// Return line updated on falling clock, driven only while shifting
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			tdo_drive <= 1'b1;
			tdo_oe <= 1'b0;
		end else if (!enabled) begin
			tdo_oe <= 1'b0; // RULE_17
		end else if (tck_fall) begin
			tdo_drive <= tdo_bit; // RULE_19
			tdo_oe <= (state == jtp_pkg::ST_SHIFT_IR) || (state == jtp_pkg::ST_SHIFT_DR); // RULE_18
		end
	end
	assign link.tdo_drive = tdo_drive;
	assign link.tdo_oe = tdo_oe;

	// Status outputs, all registered
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state_out <= 4'h0;
			instruction_out <= jtp_pkg::INSN_IDCODE;
			run_test_active_out <= 1'b0;
			port_enabled_out <= 1'b0;
		end else begin
			state_out <= state;
			instruction_out <= ir;
			// User instruction runs its function while idling
			run_test_active_out <= (state == jtp_pkg::ST_IDLE) && (ir == jtp_pkg::INSN_USER); // RULE_14
			port_enabled_out <= enabled;
		end
	end
endmodule

// file: logic/jtp_host.sv
// Scan host: makes the test clock, walks the controller, queues scan results
`timescale 1ns/1ns
module jtp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// Pointers and fill level
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage write
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
endmodule

module jtp_host #(
	parameter int HALF_CYCLES = jtp_pkg::TCK_HALF_CYCLES,
	parameter int FIFO_DEPTH = jtp_pkg::FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_reset_in,
	input wire logic [jtp_pkg::IR_WIDTH-1:0] cmd_ir_in,
	input wire logic [jtp_pkg::DR_MAX-1:0] cmd_dr_in,
	input wire logic [5:0] cmd_len_in,
	output logic cmd_ready_out,
	output logic result_valid_out,
	input wire logic result_ready_in,
	output logic [jtp_pkg::DR_MAX-1:0] result_data_out,
	jtp_link_if.host link
);
	typedef enum logic [3:0] {
		H_IDLE, H_RESET, H_IR_PRE, H_IR_SHIFT, H_IR_POST, H_DR_PRE, H_DR_SHIFT, H_DR_POST, H_PUSH
	} jtp_host_phase_type;

	jtp_host_phase_type phase;
	jtp_host_phase_type next_phase;
	logic [5:0] step; // Step index within the phase
	logic [5:0] next_step;
	logic [5:0] last_step; // Last index of the current phase
	logic [jtp_pkg::IR_WIDTH-1:0] ir; // Held command
	logic [jtp_pkg::DR_MAX-1:0] dr_out;
	logic [jtp_pkg::DR_MAX-1:0] dr_in; // Returned bits
	logic [5:0] len;
	logic [$clog2(HALF_CYCLES+1)-1:0] div; // Half-period counter
	logic tck;
	logic tms;
	logic tdi;
	logic [1:0] tdo_sync; // Return line synchroniser
	logic fall_ev; // Clock about to fall
	logic rise_ev;
	logic wrap;
	logic fifo_ready;
	logic push;
	logic next_tms;
	logic next_tdi;

	assign wrap = (phase != H_IDLE) && (phase != H_PUSH) && (div == ($bits(div))'(HALF_CYCLES - 1));
	assign rise_ev = wrap && !tck;
	assign fall_ev = wrap && tck;
	assign push = (phase == H_PUSH) && fifo_ready;

	// Last step index of each phase
	always_comb begin
		case (phase)
			H_RESET: last_step = jtp_pkg::LAST_RESET;
			H_IR_PRE: last_step = jtp_pkg::LAST_IR_PRE;
			H_IR_SHIFT: last_step = jtp_pkg::LAST_IR_SHIFT;
			H_DR_PRE: last_step = jtp_pkg::LAST_DR_PRE;
			H_DR_SHIFT: last_step = len - 6'h01;
			default: last_step = jtp_pkg::LAST_POST;
		endcase
	end

	// Step sequencing at each completed clock period
	always_comb begin
		next_phase = phase;
		next_step = step + 6'h01;
		if (step == last_step) begin
			next_step = '0;
			case (phase)
				H_IR_PRE: next_phase = H_IR_SHIFT;
				H_IR_SHIFT: next_phase = H_IR_POST;
				H_IR_POST: next_phase = H_DR_PRE;
				H_DR_PRE: next_phase = H_DR_SHIFT;
				H_DR_SHIFT: next_phase = H_DR_POST;
				H_DR_POST: next_phase = H_PUSH;
				default: next_phase = H_IDLE;
			endcase
		end
	end

	// Mode select and data for the step about to run
	always_comb begin
		next_tdi = 1'b0;
		case (next_phase)
			H_RESET: next_tms = (next_step < jtp_pkg::RESET_ONES); // RULE_15
			H_IR_PRE: next_tms = (next_step < 6'h02); // RULE_04
			H_IR_SHIFT: begin
				next_tms = (next_step == jtp_pkg::LAST_IR_SHIFT); // RULE_05
				next_tdi = ir[next_step[1:0]]; // RULE_03
			end
			// Exit1 already taken, then 1,0 finishes the 1,1,0 return
			H_IR_POST: next_tms = (next_step == '0); // RULE_08
			H_DR_PRE: next_tms = (next_step == '0); // RULE_10
			H_DR_SHIFT: begin
				next_tms = (next_step == len - 6'h01); // RULE_11
				next_tdi = dr_out[next_step[4:0]]; // RULE_03
			end
			H_DR_POST: next_tms = (next_step == '0);
			default: next_tms = 1'b0;
		endcase
	end

	// Phase, step, clock divider and pin registers
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			phase <= H_IDLE;
			step <= '0;
			div <= '0;
			tck <= 1'b0;
			tms <= 1'b1;
			tdi <= 1'b1;
			ir <= '0;
			dr_out <= '0;
			len <= jtp_pkg::LEN_BYPASS;
		end else if (phase == H_IDLE) begin
			div <= '0;
			// New scans wait for room in the result queue
			if (cmd_reset_in) begin
				phase <= H_RESET;
				step <= '0;
				tms <= 1'b1;
			end else if (cmd_valid_in && fifo_ready) begin
				phase <= H_IR_PRE;
				step <= '0;
				tms <= 1'b1;
				ir <= cmd_ir_in;
				dr_out <= cmd_dr_in;
				len <= (cmd_len_in == '0) ? jtp_pkg::LEN_BYPASS : cmd_len_in;
			end
		end else if (phase == H_PUSH) begin
			if (fifo_ready) begin
				phase <= H_IDLE;
			end
		end else begin
			div <= wrap ? '0 : div + 1'b1;
			if (wrap) begin
				tck <= !tck;
			end
			if (fall_ev) begin
				phase <= next_phase;
				step <= next_step;
				tms <= next_tms;
				tdi <= next_tdi;
			end
		end
	end

	// Return bits gathered least significant first at the end of each high phase
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			tdo_sync <= 2'h3;
			dr_in <= '0;
		end else begin
			tdo_sync <= {tdo_sync[0], link.tdo};
			if (phase == H_IDLE) begin
				dr_in <= '0;
			end else if (fall_ev && phase == H_DR_SHIFT) begin
				dr_in[step[4:0]] <= tdo_sync[1]; // RULE_03
			end
		end
	end

	// Command ready shown as a register
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			cmd_ready_out <= 1'b0;
		end else begin
			cmd_ready_out <= (phase == H_IDLE) && fifo_ready && !cmd_valid_in && !cmd_reset_in;
		end
	end

	assign link.tck = tck;
	assign link.tms = tms;
	assign link.tdi = tdi;

	// Result queue; its fullness stalls new scans
	jtp_fifo #(.WIDTH(jtp_pkg::DR_MAX), .DEPTH(FIFO_DEPTH)) result_fifo (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(dr_in),
		.out_valid_out(result_valid_out),
		.out_ready_in(result_ready_in),
		.out_data_out(result_data_out)
	);
endmodule

// file: testbench/jtp_link_asserts.sv
// Checker for the four-wire test link and the controller state it steps
`timescale 1ns/1ns
module jtp_link_asserts (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo_drive,
	input wire logic tdo_oe,
	input wire logic tdo,
	input wire logic [3:0] state_out,
	input wire logic [3:0] instruction_out,
	input wire logic port_enabled_out
);
	// Next state for mode select low and high, one nibble per state code
	localparam logic [63:0] NEXT_LOW = 64'h1BDDBBA146644311;
	localparam logic [63:0] NEXT_HIGH = 64'h2FEFCC0287855920;
	logic tck_q; // Test clock one system clock ago
	logic rise; // Test clock rising in this cycle
	logic [3:0] ref_state; // Reference controller state
	logic [2:0] ones; // Consecutive highs on mode select
	logic [2:0] ir_bit; // Instruction bits shifted so far
	logic [3:0] since_upd; // Clocks since Update-IR or reset
	logic shifting; // Reference sits in a shift state
	logic idle_move; // Reference sits in an exit or pause state
	assign rise = tck && !tck_q;
	assign shifting = (ref_state == jtp_pkg::ST_SHIFT_DR) || (ref_state == jtp_pkg::ST_SHIFT_IR);
	assign idle_move = ref_state inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE};

	// Edge finder and reference state machine, held at reset while the port is off
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			tck_q <= 1'b0;
			ref_state <= 4'h0;
		end else begin
			tck_q <= tck;
			if (!port_enabled_out) begin
				ref_state <= 4'h0;
			end else if (rise) begin
				ref_state <= tms ? NEXT_HIGH[{ref_state, 2'b00} +: 4] : NEXT_LOW[{ref_state, 2'b00} +: 4];
			end
		end
	end

	// Counters for highs in a row, instruction bits and time since an update
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			ones <= 3'h0;
			ir_bit <= 3'h0;
			since_upd <= 4'h0;
		end else begin
			if (rise) begin
				ones <= tms ? ones + {2'b00, ones != 3'h7} : 3'h0;
				ir_bit <= (ref_state == jtp_pkg::ST_SHIFT_IR) ? ir_bit + 3'h1 : 3'h0;
			end
			if (ref_state == 4'hF || ref_state == 4'h0) begin
				since_upd <= 4'h0;
			end else if (since_upd != 4'hF) begin
				since_upd <= since_upd + 4'h1;
			end
		end
	end

	a_state_tracks_ref: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise |-> ##6 state_out == ref_state) else $error("Controller state differs from reference");
	a_reset_start: assert property (
		@(posedge clock_in) disable iff (reset_in)
		$fell(reset_in) |-> state_out == 4'h0 && !tdo_oe) else $error("Controller not in reset state");
	a_five_highs: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise && tms && ones == 3'h4 |-> ##6 state_out == 4'h0) else $error("Five highs did not reset");
	a_drive_only_shift: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise && tdo_oe |-> shifting) else $error("Return line driven outside shift");
	a_drive_in_shift: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise && shifting |-> tdo_oe) else $error("Return line not driven in shift");
	a_exit_no_action: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise && idle_move |-> !tdo_oe && $stable(instruction_out)) else $error("Action in exit or pause");
	a_tdo_after_fall: assert property (
		@(posedge clock_in) disable iff (reset_in)
		tck && tck_q |-> $stable(tdo_drive) && $stable(tdo_oe)) else $error("Return line moved in high phase");
	a_ir_capture_out: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		rise && ref_state == jtp_pkg::ST_SHIFT_IR && ir_bit < 3'h4 |-> tdo == jtp_pkg::IR_CAPTURE[ir_bit[1:0]])
		else $error("Wrong instruction capture bit");
	a_ir_update_only: assert property (
		@(posedge clock_in) disable iff (reset_in || !port_enabled_out)
		!$stable(instruction_out) |-> since_upd < 4'hC) else $error("Instruction changed outside update");
endmodule

// file: testbench/jtag_tap_controller_tb_top.sv
// Testbench joining host and controller across the test link
`timescale 1ns/1ns
module jtag_tap_controller_tb_top;
	logic clock_in; // System clock
	logic reset_in; // Power-on reset
	logic fuse; // Port enable fuse
	logic disable_bit; // Port disable bit
	logic [7:0] user_capture; // Parallel value for user capture
	logic cmd_valid, cmd_reset, cmd_ready, result_valid, result_ready; // Host handshakes
	logic [3:0] cmd_ir, state_out, instruction_out; // Command and controller state
	logic [31:0] cmd_dr, result_data; // Scan data in and out
	logic [5:0] cmd_len; // Data bits per scan
	logic [7:0] user_data; // User register output
	logic run_test_active, port_enabled; // Controller flags
	int fail_count = 0; // Mismatches
	int checks_done = 0; // Comparisons
	int cycle_count = 0; // Cycles run

	jtp_link_if u_jtp_link_if ();
	jtp_device u_jtp_device (.clock_in(clock_in), .reset_in(reset_in), .test_port_enable_fuse_in(fuse),
		.test_port_disable_bit_in(disable_bit), .user_capture_in(user_capture), .link(u_jtp_link_if),
		.state_out(state_out), .instruction_out(instruction_out), .user_data_out(user_data),
		.run_test_active_out(run_test_active), .port_enabled_out(port_enabled));
	jtp_host u_jtp_host (.clock_in(clock_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid),
		.cmd_reset_in(cmd_reset), .cmd_ir_in(cmd_ir), .cmd_dr_in(cmd_dr), .cmd_len_in(cmd_len),
		.cmd_ready_out(cmd_ready), .result_valid_out(result_valid), .result_ready_in(result_ready),
		.result_data_out(result_data), .link(u_jtp_link_if));
	jtp_link_asserts u_jtp_link_asserts (.clock_in(clock_in), .reset_in(reset_in), .tck(u_jtp_link_if.tck),
		.tms(u_jtp_link_if.tms), .tdo_drive(u_jtp_link_if.tdo_drive), .tdo_oe(u_jtp_link_if.tdo_oe),
		.tdo(u_jtp_link_if.tdo), .state_out(state_out), .instruction_out(instruction_out),
		.port_enabled_out(port_enabled));

	// System clock, 40 ns period
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// Cycle ceiling cuts a hang short
	always @(posedge clock_in) begin
		cycle_count++;
		if (cycle_count == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// Counts and verdict, then stop
	task automatic final_report();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Compare one value and count it
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// Give one command once the host is ready; a reset walk when rst is high
	task automatic send(input logic rst, input logic [3:0] ir, input logic [31:0] dr, input logic [5:0] len);
		int n = 0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		fail_count += (n == 3000) ? 1 : 0; // Host never became ready
		cmd_reset = rst;
		cmd_valid = !rst;
		cmd_ir = ir;
		cmd_dr = dr;
		cmd_len = len;
		@(negedge clock_in);
		cmd_valid = 1'b0;
		cmd_reset = 1'b0;
	endtask

	// Wait for a result word, compare its masked bits, pop it
	task automatic pop_check(input string what, input logic [31:0] exp, input logic [31:0] mask);
		int n = 0;
		while (result_valid !== 1'b1 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		check_word(what, exp, (result_valid === 1'b1) ? (result_data & mask) : ~exp);
		result_ready = 1'b1;
		@(negedge clock_in);
		result_ready = 1'b0;
		@(negedge clock_in);
	endtask

	// Values straight after reset, and the pulled-up return line
	task automatic t_reset_values();
		check_word("state after reset", 32'h0, 32'(state_out));
		check_word("instruction after reset", 32'h1, 32'(instruction_out));
		check_word("idle return level", 32'h1, 32'(u_jtp_link_if.tdo));
	endtask

	// Two user scans back to back: capture out, latched output in
	task automatic t_user();
		logic [7:0] cap, dat;
		for (int i = 0; i < 2; i++) begin
			cap = (i == 0) ? 8'h3C : 8'hC3;
			dat = (i == 0) ? 8'hA5 : 8'h5A;
			user_capture = cap;
			send(1'b0, jtp_pkg::INSN_USER, 32'(dat), jtp_pkg::LEN_USER);
			pop_check("user capture", 32'(cap), 32'hFF);
			check_word("user output", 32'(dat), 32'(user_data));
			check_word("instruction", 32'(jtp_pkg::INSN_USER), 32'(instruction_out));
			check_word("idle function", 32'h1, 32'(run_test_active));
		end
	endtask

	// One-bit bypass path delays the data by one bit after a zero
	task automatic t_bypass();
		send(1'b0, jtp_pkg::INSN_BYPASS, 32'h5A, 6'h08);
		pop_check("bypass return", 32'hB4, 32'hFF);
		check_word("user output kept", 32'h5A, 32'(user_data));
		check_word("idle function off", 32'h0, 32'(run_test_active));
	endtask

	// Fill the result queue, have one command refused, drain in order
	task automatic t_fifo();
		for (int i = 0; i < 8; i++) begin
			send(1'b0, jtp_pkg::INSN_BYPASS, 32'(i % 2 == 0), 6'h02);
		end
		// Long enough for the last two-bit scan to land
		repeat (300) @(negedge clock_in);
		check_word("ready when full", 32'h0, 32'(cmd_ready));
		cmd_dr = 32'h1;
		cmd_valid = 1'b1;
		repeat (4) @(negedge clock_in);
		cmd_valid = 1'b0;
		repeat (300) @(negedge clock_in);
		for (int i = 0; i < 8; i++) begin
			pop_check("queued word", (i % 2 == 0) ? 32'h2 : 32'h0, 32'h3);
		end
		repeat (300) @(negedge clock_in);
		check_word("empty after drain", 32'h0, 32'(result_valid));
	endtask

	// Reset walk: five mode select highs through reset, then one low into idle
	task automatic t_tms_reset();
		send(1'b1, 4'h0, 32'h0, 6'h01);
		repeat (100) @(negedge clock_in);
		check_word("state after walk", 32'(jtp_pkg::ST_IDLE), 32'(state_out));
	endtask

	// Identification scan, whole 32-bit word least significant bit first
	task automatic t_idcode();
		send(1'b0, jtp_pkg::INSN_IDCODE, 32'h0, jtp_pkg::LEN_ID);
		pop_check("identification word", jtp_pkg::ID_VALUE, 32'hFFFFFFFF);
		check_word("instruction", 32'(jtp_pkg::INSN_IDCODE), 32'(instruction_out));
	endtask

	// Fuse clear and disable bit each hold the port off; then it comes back
	task automatic t_disabled();
		fuse = 1'b0;
		repeat (4) @(negedge clock_in);
		check_word("enabled with fuse clear", 32'h0, 32'(port_enabled));
		send(1'b0, jtp_pkg::INSN_USER, 32'h0, jtp_pkg::LEN_USER);
		pop_check("return from off port", 32'hFF, 32'hFF);
		check_word("state with fuse clear", 32'h0, 32'(state_out));
		fuse = 1'b1;
		disable_bit = 1'b1;
		repeat (4) @(negedge clock_in);
		check_word("enabled with disable bit", 32'h0, 32'(port_enabled));
		disable_bit = 1'b0;
		repeat (4) @(negedge clock_in);
		check_word("enabled again", 32'h1, 32'(port_enabled));
		t_tms_reset();
		t_idcode();
	endtask

	// Main sequence
	initial begin
		reset_in = 1'b1;
		fuse = 1'b1;
		disable_bit = 1'b0;
		user_capture = 8'h00;
		cmd_valid = 1'b0;
		cmd_reset = 1'b0;
		cmd_ir = 4'h0;
		cmd_dr = 32'h0;
		cmd_len = 6'h00;
		result_ready = 1'b0;
		repeat (10) @(negedge clock_in);
		reset_in = 1'b0;
		repeat (2) @(negedge clock_in);
		t_reset_values();
		t_tms_reset();
		t_user();
		t_bypass();
		t_fifo();
		t_tms_reset();
		t_idcode();
		t_disabled();
		final_report();
	end
endmodule
